/* inc/spifc_regs.svh */
`ifndef SPIFC_REGS_SVH
`define SPIFC_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SPIFC_OFS_STATUS  8'h00
`define SPIFC_OFS_RXDATA  8'h04
`define SPIFC_OFS_TXDATA  8'h08
`define SPIFC_OFS_CTRL    8'h10

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define SPIFC_CTRL_EN      0
`define SPIFC_CTRL_TRIG    6
`define SPIFC_CTRL_ZFILL   7
`define SPIFC_CTRL_LOOP    10
`define SPIFC_CTRL_CONT    11
`define SPIFC_CTRL_RFLUSH  12
`define SPIFC_CTRL_TFLUSH  13
`define SPIFC_CTRL_THR_LO  14
`define SPIFC_CTRL_MASK    32'h0000FCC1
`define SPIFC_CTRL_RESET   32'h00000000

// ----------------------------------------
// Data and timing
// ----------------------------------------
`define SPIFC_FILL_ZERO    8'h00
`define SPIFC_LAST_BIT     3'h7
`define SPIFC_GAP_LCLK     2'h2

`endif

/* inc/spifc_pkg.sv */
package spifc_pkg;

  typedef logic [7:0] spifc_byte_t;

  typedef enum logic [3:0] {
    SPIFC_L_IDLE  = 4'h1,
    SPIFC_L_SHIFT = 4'h2,
    SPIFC_L_HOLD  = 4'h4,
    SPIFC_L_GAP   = 4'h8
  } spifc_lstate_t;

endpackage : spifc_pkg

/* inc/spifc_xfer_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface spifc_xfer_if;
  import spifc_pkg::*;
  logic        req_tog;
  spifc_byte_t tx_byte;
  logic        keep_cs;
  logic        loop_en;
  logic        ack_tog;
  spifc_byte_t rx_byte;

  modport core (output req_tog, output tx_byte, output keep_cs, output loop_en,
                input ack_tog, input rx_byte);
  modport link (input req_tog, input tx_byte, input keep_cs, input loop_en,
                output ack_tog, output rx_byte);
endinterface : spifc_xfer_if

`default_nettype wire

/* src/spifc_link.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spifc_regs.svh"

module spifc_link (
  spifc_xfer_if.link x,
  input  wire logic  lclk,
  input  wire logic  hresetn,
  input  wire logic  miso,
  output logic       sclk,
  output logic       mosi,
  output logic       cs_n
);
  import spifc_pkg::*;

  logic [1:0]    rst_s;
  logic [2:0]    req_s;
  logic [2:0]    loop_s;
  logic          req_seen_r;
  logic          req_used_r;
  logic          loop_r;
  spifc_lstate_t state_r;
  logic [2:0]    bit_cnt_r;
  logic          ph_r;
  logic [1:0]    gap_r;
  spifc_byte_t   sh_r;
  spifc_byte_t   rx_r;
  logic          keep_r;
  logic          ack_r;

  // ----------------------------------------
  // Reset release and crossings
  // ----------------------------------------
  // Release is synchronised so the link never starts on a partial edge
  always_ff @(posedge lclk or negedge hresetn) begin
    if (!hresetn) rst_s <= 2'h0;
    else rst_s <= {rst_s[0], 1'b1};
  end

  wire lrst_n = rst_s[1];

  always_ff @(posedge lclk or negedge lrst_n) begin
    if (!lrst_n) begin
      req_s      <= 3'h0;
      loop_s     <= 3'h0;
      req_seen_r <= 1'b0;
      loop_r     <= 1'b0;
    end else begin
      req_s  <= {req_s[1:0], x.req_tog};
      loop_s <= {loop_s[1:0], x.loop_en};
      if (req_s[2] == req_s[1]) req_seen_r <= req_s[2];
      if (loop_s[2] == loop_s[1]) loop_r <= loop_s[2];
    end
  end

  wire new_req = (req_seen_r != req_used_r);
  wire in_bit  = loop_r ? mosi : miso;

  // ----------------------------------------
  // Shifter
  // ----------------------------------------
  always_ff @(posedge lclk or negedge lrst_n) begin
    if (!lrst_n) begin
      state_r <= SPIFC_L_IDLE;
      req_used_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      ph_r <= 1'b0;
      gap_r <= 2'h0;
      sh_r <= 8'h00;
      rx_r <= 8'h00;
      keep_r <= 1'b0;
      ack_r <= 1'b0;
      sclk <= 1'b0;
      mosi <= 1'b0;
      cs_n <= 1'b1;
    end else begin
      case (state_r)
        SPIFC_L_IDLE, SPIFC_L_HOLD: begin
          if (new_req) begin
            req_used_r <= req_seen_r;
            sh_r <= x.tx_byte;
            mosi <= x.tx_byte[7];
            keep_r <= x.keep_cs;
            cs_n <= 1'b0;
            bit_cnt_r <= 3'h0;
            ph_r <= 1'b0;
            state_r <= SPIFC_L_SHIFT;
          end
        end
        SPIFC_L_SHIFT: begin
          if (!ph_r) begin
            sclk <= 1'b1;
            sh_r <= {sh_r[6:0], in_bit};
            ph_r <= 1'b1;
          end else begin
            sclk <= 1'b0;
            ph_r <= 1'b0;
            if (bit_cnt_r == `SPIFC_LAST_BIT) begin
              rx_r <= sh_r;
              ack_r <= ~ack_r;
              if (keep_r) begin
                state_r <= SPIFC_L_HOLD;
              end else begin
                cs_n <= 1'b1;
                gap_r <= `SPIFC_GAP_LCLK - 2'h1;
                state_r <= SPIFC_L_GAP;
              end
            end else begin
              bit_cnt_r <= bit_cnt_r + 3'h1;
              mosi <= sh_r[7];
            end
          end
        end
        SPIFC_L_GAP: begin
          if (gap_r == 2'h0) state_r <= SPIFC_L_IDLE;
          else gap_r <= gap_r - 2'h1;
        end
        default: state_r <= SPIFC_L_IDLE;
      endcase
    end
  end

  assign x.ack_tog = ack_r;
  assign x.rx_byte = rx_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking lcb @(posedge lclk); endclocking
  default disable iff (!lrst_n);

  cs_run_hold_a: assert property ((state_r == SPIFC_L_HOLD) |-> !cs_n)
    else $error("chip select released inside a continuous run");
  byte_len_a: assert property (($past(state_r) != SPIFC_L_SHIFT && state_r == SPIFC_L_SHIFT)
    |-> ##[15:16] $changed(ack_r))
    else $error("byte did not complete in eight serial clocks");
  gap_idle_a: assert property (($changed(ack_r) && !keep_r) |-> cs_n [*3])
    else $error("next byte started without the idle serial clock");
  loop_bit_a: assert property ((loop_r && state_r == SPIFC_L_SHIFT && !ph_r)
    |=> sh_r[0] == $past(mosi))
    else $error("loopback did not return the outgoing bit");
endmodule : spifc_link

`default_nettype wire

/* src/spifc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spifc_regs.svh"


module spifc_top #(
  parameter int DEPTH = 4
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        lclk,
  input  wire logic        spi_miso,
  output logic             spi_sclk,
  output logic             spi_mosi,
  output logic             spi_cs_n,
  output logic             spi_irq
);
  import spifc_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  function automatic logic [CW-1:0] thr_bytes(input logic [1:0] m);
    thr_bytes = CW'(m) + CW'(1);
  endfunction : thr_bytes

  spifc_xfer_if xif ();

  logic                pend_r;
  logic                wr_r;
  logic [7:0]          ofs_r;
  logic [31:0]         ctrl_r;
  spifc_byte_t         tx_mem [DEPTH];
  spifc_byte_t         rx_mem [DEPTH];
  logic [AW-1:0]       tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic [CW-1:0]       tx_cnt_r, rx_cnt_r, sent_cnt_r;
  logic                busy_r;
  logic                req_tog_r;
  spifc_byte_t         tx_byte_r;
  spifc_byte_t         last_tx_r;
  logic                keep_r;
  logic                trig_pend_r;
  logic [2:0]          ack_s;
  logic                ack_seen_r;
  logic                ack_used_r;
  logic                tx_irq_r, rx_irq_r, ovf_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire addr_take = hsel & htrans[1] & hready;
  wire is_st     = (ofs_r == `SPIFC_OFS_STATUS);
  wire is_rx     = (ofs_r == `SPIFC_OFS_RXDATA);
  wire is_tx     = (ofs_r == `SPIFC_OFS_TXDATA);
  wire is_ctrl   = (ofs_r == `SPIFC_OFS_CTRL);
  wire wr_ctrl   = pend_r & wr_r & is_ctrl;
  wire wr_tx     = pend_r & wr_r & is_tx;
  wire rd_rx     = pend_r & ~wr_r & is_rx;
  wire rd_st     = pend_r & ~wr_r & is_st;

  wire       en     = ctrl_r[`SPIFC_CTRL_EN];
  wire       trig   = ctrl_r[`SPIFC_CTRL_TRIG];
  wire       zfill  = ctrl_r[`SPIFC_CTRL_ZFILL];
  wire       cont   = ctrl_r[`SPIFC_CTRL_CONT];
  wire       rflush = ctrl_r[`SPIFC_CTRL_RFLUSH];
  wire       tflush = ctrl_r[`SPIFC_CTRL_TFLUSH];
  wire [1:0] thr    = ctrl_r[`SPIFC_CTRL_THR_LO +: 2];
  wire [CW-1:0] thr_n = thr_bytes(thr);

  // ----------------------------------------
  // Engine decode
  // ----------------------------------------
  wire done     = busy_r & (ack_seen_r != ack_used_r);
  wire tx_avail = (tx_cnt_r != '0) & ~tflush;
  // start by write or by read
  wire launch   = en & ~busy_r & (trig ? tx_avail : trig_pend_r);
  wire spifc_byte_t fill = zfill ? `SPIFC_FILL_ZERO : last_tx_r;
  wire spifc_byte_t launch_byte = tx_avail ? tx_mem[tx_rp_r] : fill;
  wire keep_nxt = cont & trig & ~tflush & (tx_cnt_r > CW'(1));

  wire push_tx  = wr_tx & ~tflush & (tx_cnt_r != FULL);
  wire pop_tx   = launch & tx_avail;
  wire rx_take  = done & ~rflush;
  wire push_rx  = rx_take & (rx_cnt_r != FULL);
  wire pop_rx   = rd_rx & (rx_cnt_r != '0) & ~rflush;
  wire spifc_byte_t rx_head = (rx_cnt_r != '0) ? rx_mem[rx_rp_r] : 8'h00;

  wire tx_hit  = done & trig & (sent_cnt_r + CW'(1) >= thr_n);
  wire rx_hit  = push_rx & ~trig & (rx_cnt_r + CW'(1) >= thr_n);
  wire ovf_hit = rx_take & (rx_cnt_r == FULL);
  wire tx_irq_nxt = (tx_irq_r & ~rd_st) | (tx_hit & ~rflush);
  wire rx_irq_nxt = (rx_irq_r & ~rd_st) | (rx_hit & ~rflush);
  wire ovf_nxt    = (ovf_r & ~rd_st) | (ovf_hit & ~rflush);
  wire excess  = (rx_cnt_r > thr_n);
  wire any_irq = tx_irq_r | rx_irq_r | ovf_r;

  wire [31:0] st_word = {20'h0, excess, rx_cnt_r, ovf_r, rx_irq_r, tx_irq_r, 1'b0,
                         tx_cnt_r, any_irq};
  wire [31:0] rd_mux  = is_st   ? st_word :
                        is_rx   ? {24'h0, rx_head} :
                        is_ctrl ? ctrl_r : 32'h0;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // One wait state keeps hrdata registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      wr_r <= 1'b0;
      ofs_r <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
      hresp <= 1'b0;
    end else if (addr_take) begin
      pend_r <= 1'b1;
      wr_r <= hwrite;
      ofs_r <= haddr[7:0];
      hreadyout <= 1'b0;
    end else if (pend_r) begin
      pend_r <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= wr_r ? 32'h0 : rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl_r <= `SPIFC_CTRL_RESET;
    else if (wr_ctrl) ctrl_r <= hwdata & `SPIFC_CTRL_MASK;
  end

  // ----------------------------------------
  // FIFOs
  // ----------------------------------------
  // Pointers wrap by width, so DEPTH must be a power of two
  always_ff @(posedge hclk) begin
    if (push_tx) tx_mem[tx_wp_r] <= hwdata[7:0];
    if (push_rx) rx_mem[rx_wp_r] <= xif.rx_byte;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
    end else if (tflush) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (push_tx) tx_wp_r <= tx_wp_r + AW'(1);
      if (pop_tx) tx_rp_r <= tx_rp_r + AW'(1);
      tx_cnt_r <= tx_cnt_r + CW'(push_tx) - CW'(pop_tx);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
    end else if (rflush) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
    end else begin
      if (push_rx) rx_wp_r <= rx_wp_r + AW'(1);
      if (pop_rx) rx_rp_r <= rx_rp_r + AW'(1);
      rx_cnt_r <= rx_cnt_r + CW'(push_rx) - CW'(pop_rx);
    end
  end

  // ----------------------------------------
  // Transfer engine and crossing
  // ----------------------------------------
  // Byte and keep stay still from toggle to acknowledge, so the link may sample them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
      req_tog_r <= 1'b0;
      tx_byte_r <= 8'h00;
      last_tx_r <= 8'h00;
      keep_r <= 1'b0;
    end else if (launch) begin
      busy_r <= 1'b1;
      req_tog_r <= ~req_tog_r;
      tx_byte_r <= launch_byte;
      last_tx_r <= launch_byte;
      keep_r <= keep_nxt;
    end else if (done) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) trig_pend_r <= 1'b0;
    else trig_pend_r <= (trig_pend_r & ~launch) | (rd_rx & ~trig);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_s <= 3'h0;
      ack_seen_r <= 1'b0;
      ack_used_r <= 1'b0;
    end else begin
      ack_s <= {ack_s[1:0], xif.ack_tog};
      if (ack_s[2] == ack_s[1]) ack_seen_r <= ack_s[2];
      if (done) ack_used_r <= ack_seen_r;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sent_cnt_r <= '0;
      tx_irq_r <= 1'b0;
      rx_irq_r <= 1'b0;
      ovf_r <= 1'b0;
      spi_irq <= 1'b0;
    end else begin
      if (tx_hit) sent_cnt_r <= '0;
      else if (done & trig) sent_cnt_r <= sent_cnt_r + CW'(1);
      tx_irq_r <= tx_irq_nxt;
      rx_irq_r <= rx_irq_nxt;
      ovf_r <= ovf_nxt;
      spi_irq <= tx_irq_nxt | rx_irq_nxt | ovf_nxt;
    end
  end

  assign xif.req_tog = req_tog_r;
  assign xif.tx_byte = tx_byte_r;
  assign xif.keep_cs = keep_r;
  assign xif.loop_en = ctrl_r[`SPIFC_CTRL_LOOP];

  spifc_link u_link (
    .x       (xif),
    .lclk    (lclk),
    .hresetn (hresetn),
    .miso    (spi_miso),
    .sclk    (spi_sclk),
    .mosi    (spi_mosi),
    .cs_n    (spi_cs_n)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking hcb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rx_read_flush;
    rd_rx && rflush && !trig && en && !busy_r && !trig_pend_r;
  endsequence

  tx_thr_irq_a: assert property ((done && trig && !rflush
    && sent_cnt_r + CW'(1) == thr_n) |=> tx_irq_r)
    else $error("transmit interrupt missed at threshold");
  tx_early_a: assert property ($rose(tx_irq_r) |-> $past(sent_cnt_r) + CW'(1) >= $past(thr_n))
    else $error("transmit interrupt raised before threshold");
  rx_thr_irq_a: assert property ((push_rx && !pop_rx && !trig && !rflush
    && rx_cnt_r + CW'(1) == thr_n) |=> rx_irq_r && rx_cnt_r == $past(thr_n))
    else $error("receive interrupt missed at threshold");
  rx_full_irq_a: assert property ((push_rx && !trig && !rflush && thr == 2'h3
    && rx_cnt_r + CW'(1) == FULL) |=> rx_irq_r)
    else $error("receive interrupt missed when full");
  tx_flush_a: assert property (tflush |=> tx_cnt_r == '0 && !$past(pop_tx))
    else $error("transmit FIFO not emptied by flush");
  flush_fill_a: assert property ((launch && tflush && !zfill)
    |=> tx_byte_r == $past(last_tx_r))
    else $error("flush did not repeat the last byte");
  tx_drop_a: assert property ((wr_tx && tflush) ##1 tflush |=> tx_cnt_r == '0)
    else $error("write accepted during transmit flush");
  rx_flush_a: assert property (rflush |=> rx_cnt_r == '0)
    else $error("receive FIFO not emptied by flush");
  rx_quiet_a: assert property ($past(rflush) |-> !$rose(rx_irq_r) && !$rose(ovf_r))
    else $error("interrupt raised during receive flush");
  read_start_a: assert property (s_rx_read_flush |-> ##2 busy_r)
    else $error("receive read did not start a transfer");
  zero_fill_a: assert property ((launch && !tx_avail && zfill)
    |=> tx_byte_r == `SPIFC_FILL_ZERO)
    else $error("zero fill not sent on empty FIFO");
  ovf_irq_a: assert property ((ovf_hit && !rflush) |=> ovf_r && spi_irq)
    else $error("overflow did not interrupt");
endmodule : spifc_top

`default_nettype wire

/* sim/spifc_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Mode 0 slave, MSB first, counts bytes and frames seen from the master
module spifc_slave_model (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       cs_n,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      last_rx,
  output int              nbytes,
  output int              nframes,
  output logic            short_gap
);
  logic [7:0] sh_in;
  logic [7:0] sh_out;
  int         bits;
  realtime    t_rise;

  initial begin
    miso = 1'b0;
    last_rx = 8'h00;
    nbytes = 0;
    nframes = 0;
    short_gap = 1'b0;
    bits = 0;
    t_rise = 0.0;
  end

  // Gaps under one serial clock (two link clocks) are flagged
  always @(negedge cs_n) begin
    if (nframes > 0 && $realtime - t_rise < 250.0) begin
      short_gap = 1'b1;
    end
    sh_out = reply;
    miso = reply[7];
    bits = 0;
  end

  // Released line shows the inverse, so a stale sample cannot pass
  always @(posedge cs_n) begin
    t_rise = $realtime;
    nframes++;
    miso = ~miso;
  end

  always @(negedge sclk) begin
    if (!cs_n) begin
      sh_out = {sh_out[6:0], 1'b0};
      miso = sh_out[7];
    end
  end

  always @(posedge sclk) begin
    if (!cs_n) begin
      sh_in = {sh_in[6:0], mosi};
      bits++;
      if (bits == 8) begin
        last_rx = sh_in;
        nbytes++;
        bits = 0;
      end
    end
  end
endmodule : spifc_slave_model

`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spifc_regs.svh"

module tb_top;
  import spifc_pkg::*;

  localparam logic [7:0] st_a = `SPIFC_OFS_STATUS;
  localparam logic [7:0] rx_a = `SPIFC_OFS_RXDATA;
  localparam logic [7:0] tx_a = `SPIFC_OFS_TXDATA;
  localparam logic [7:0] ct_a = `SPIFC_OFS_CTRL;

  logic        hclk;
  logic        lclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        spi_miso;
  logic        spi_sclk;
  logic        spi_mosi;
  logic        spi_cs_n;
  logic        spi_irq;
  logic [7:0]  reply;
  logic [7:0]  slv_last;
  logic        slv_short;
  int          slv_bytes;
  int          slv_frames;
  int          fails;
  int          tests_run;
  int          sent;
  int          f0;

  spifc_top #(.DEPTH(4)) u_spifc_top (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .lclk      (lclk),
    .spi_miso  (spi_miso),
    .spi_sclk  (spi_sclk),
    .spi_mosi  (spi_mosi),
    .spi_cs_n  (spi_cs_n),
    .spi_irq   (spi_irq)
  );

  spifc_slave_model u_spifc_slave_model (
    .sclk      (spi_sclk),
    .mosi      (spi_mosi),
    .cs_n      (spi_cs_n),
    .reply     (reply),
    .miso      (spi_miso),
    .last_rx   (slv_last),
    .nbytes    (slv_bytes),
    .nframes   (slv_frames),
    .short_gap (slv_short)
  );

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    lclk = 1'b0;
    #1.3;
    forever #62.5 lclk = ~lclk;
  end

  // ----
  // Checking and bus tasks
  // ----
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stall();
    fails++;
    $display("unexpected at %0t: wait limit reached", $time);
    finish_test();
  endtask : stall

  // Ready and read data are taken at the rising edge, before the slave's update lands
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
    if (n >= 100) stall();
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r & m, e);
  endtask : rdm

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rdm(a, 32'hFFFFFFFF, e);
  endtask : rdc

  // Waits for n more bytes at the slave and for chip select to be released (spi_cs_n high)
  task automatic wait_tx(input int n);
    int k;
    k = 0;
    sent += n;
    while ((slv_bytes < sent || spi_cs_n !== 1'b1) && k < 20000) begin
      @(posedge hclk);
      k++;
    end
    repeat (12) @(posedge hclk);
    if (k >= 20000) stall();
  endtask : wait_tx

  // ----
  // Main sequence
  // ----
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    reply = 8'hC3;
    fails = 0;
    tests_run = 0;
    sent = 0;
    // Counted in link clocks: the slow domain needs its own reset edges
    repeat (6) @(posedge lclk);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(st_a, 32'h0);
    rdc(8'h20, 32'h0);
    wr(ct_a, 32'hFFFFFFFF);
    rdc(ct_a, 32'h0000FCC1);
    wr(ct_a, 32'h0);
    for (int t = 0; t < 4; t++) begin
      wr(ct_a, 32'h41 | (t << 14));
      for (int k = 0; k <= t; k++) begin
        check({31'h0, spi_irq}, 32'h0);
        wr(tx_a, 32'h10 + k);
        wait_tx(1);
        check({24'h0, slv_last}, 32'h10 + k);
        rdc(rx_a, 32'hC3);
      end
      check({31'h0, spi_irq}, 32'h1);
      rdm(st_a, 32'h2F, 32'h21);
    end
    wr(ct_a, 32'hC840);
    for (int k = 0; k < 4; k++) wr(tx_a, 32'hA0 + k);
    rdc(st_a, 32'h8);
    f0 = slv_frames;
    wr(ct_a, 32'hC841);
    wait_tx(4);
    check(32'(slv_frames - f0), 32'h1);
    check({24'h0, slv_last}, 32'hA3);
    rdc(st_a, 32'h421);
    wr(tx_a, 32'hB0);
    wait_tx(1);
    check({31'h0, spi_irq}, 32'h1);
    rdc(st_a, 32'h481);
    wr(ct_a, 32'h41);
    rdm(st_a, 32'hF00, 32'hC00);
    wr(ct_a, 32'h1041);
    wr(tx_a, 32'hB1);
    wait_tx(1);
    check({31'h0, spi_irq}, 32'h0);
    rdc(st_a, 32'h0);
    wr(ct_a, 32'h401);
    wr(tx_a, 32'hA5);
    rdc(rx_a, 32'h0);
    wait_tx(1);
    check({24'h0, slv_last}, 32'hA5);
    rdc(st_a, 32'h141);
    rdc(rx_a, 32'hA5);
    wait_tx(1);
    check({24'h0, slv_last}, 32'hA5);
    wr(ct_a, 32'h81);
    rdc(rx_a, 32'hA5);
    wait_tx(1);
    check({24'h0, slv_last}, 32'h0);
    rdc(rx_a, 32'hC3);
    wait_tx(1);
    rdc(st_a, 32'h141);
    wr(ct_a, 32'h1081);
    rdc(st_a, 32'h0);
    rdc(rx_a, 32'h0);
    wait_tx(1);
    rdc(st_a, 32'h0);
    wr(ct_a, 32'h0);
    wr(tx_a, 32'h77);
    rdc(st_a, 32'h2);
    wr(ct_a, 32'h2000);
    rdc(st_a, 32'h0);
    wr(tx_a, 32'h11);
    rdc(st_a, 32'h0);
    wr(ct_a, 32'h2001);
    rdc(rx_a, 32'h0);
    wait_tx(1);
    check({24'h0, slv_last}, 32'h0);
    wr(ct_a, 32'h41);
    f0 = slv_frames;
    wr(tx_a, 32'h3C);
    wr(tx_a, 32'h5A);
    wait_tx(2);
    check(32'(slv_frames - f0), 32'h2);
    check({24'h0, slv_last}, 32'h5A);
    check({31'h0, slv_short}, 32'h0);
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
